//--- design/cbc_pkg.sv
// constants and types shared by the transfer and bit-control execution unit
// assumes a 20 MHz core clock and a classic wishbone register port
package cbc_pkg;

  // ----------------------------------------------------------------
  // register offsets, byte addresses on the wishbone port
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INSTR    = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_GPR_SEL  = 8'h08;
  localparam logic [7:0] OFS_GPR_DATA = 8'h0C;
  localparam logic [7:0] OFS_PTR_EXT  = 8'h10;
  localparam logic [7:0] OFS_STACK    = 8'h14;
  localparam logic [7:0] OFS_CYCLES   = 8'h18;

  // ----------------------------------------------------------------
  // instruction word fields and status word layout
  // ----------------------------------------------------------------
  localparam int F_OP_LSB  = 0;
  localparam int OP_W      = 5;
  localparam int F_REG_LSB = 5;
  localparam int REG_W     = 5;
  localparam int F_BIT_LSB = 10;
  localparam int BIT_W     = 3;
  localparam int F_IOA_LSB = 13;
  localparam int IOA_W     = 6;
  localparam int ST_BUSY   = 8;

  // status_register flag positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;

  // ----------------------------------------------------------------
  // reset values and fixed operands
  // ----------------------------------------------------------------
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [7:0]  EXT_RESET  = 8'h00;
  localparam logic [15:0] SP_RESET   = 16'h0FFF;
  localparam logic [7:0]  ONES       = 8'hFF;
  localparam logic [23:0] PSTORE_STEP = 24'h000002;
  localparam logic [4:0]  R_LO       = 5'h00;
  localparam logic [4:0]  R_HI       = 5'h01;
  localparam logic [4:0]  R_ZLO      = 5'h1E;
  localparam logic [4:0]  R_ZHI      = 5'h1F;

  typedef enum logic [4:0] {
    OP_IDLE   = 5'h00, OP_BRK   = 5'h01, OP_SLP   = 5'h02, OP_WATCH = 5'h03,
    OP_PSTORE = 5'h04, OP_IN    = 5'h05, OP_OUT   = 5'h06, OP_PUSH  = 5'h07,
    OP_POP    = 5'h08, OP_EXCH  = 5'h09, OP_LDSET = 5'h0A, OP_LDCLR = 5'h0B,
    OP_LDTGL  = 5'h0C, OP_SHL   = 5'h0D, OP_SHR   = 5'h0E, OP_RCL   = 5'h0F,
    OP_RCR    = 5'h10, OP_SAR   = 5'h11, OP_IOSET = 5'h12, OP_IOCLR = 5'h13,
    OP_TSTORE = 5'h14, OP_TLOAD = 5'h15, OP_FSET  = 5'h16, OP_FCLR  = 5'h17
  } cbc_op_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b001,
    S_EXEC   = 3'b010,
    S_SECOND = 3'b100
  } cbc_state_t;

endpackage

//--- design/cbc_shift.sv
// shift and rotate unit: result and updated flags for one byte
// assumes the caller only uses the outputs for shift and rotate opcodes
`timescale 1ns/100ps
module cbc_shift (
  input  logic [4:0] op,
  input  logic [7:0] value,
  input  logic [7:0] flags_in,
  output logic [7:0] result,
  output logic [7:0] flags_out
);

  logic c_out;

  // ----------------------------------------------------------------
  // data path and flags
  // ----------------------------------------------------------------
  always_comb begin
    result   = value;
    c_out     = flags_in[cbc_pkg::FL_C];
    flags_out = flags_in;
    unique case (op)
      cbc_pkg::OP_SHL: result = {value[6:0], 1'b0};
      cbc_pkg::OP_RCL: result = {value[6:0], flags_in[cbc_pkg::FL_C]};
      cbc_pkg::OP_SHR: result = {1'b0, value[7:1]};
      cbc_pkg::OP_RCR: result = {flags_in[cbc_pkg::FL_C], value[7:1]};
      cbc_pkg::OP_SAR: result = {value[7], value[7:1]};
      default:         result = value;
    endcase
    // left moves take carry from bit 7, right moves from bit 0
    if (op == cbc_pkg::OP_SHL || op == cbc_pkg::OP_RCL) begin
      c_out = value[7];
      flags_out[cbc_pkg::FL_H] = value[3];
    end else begin
      c_out = value[0];
    end
    flags_out[cbc_pkg::FL_C] = c_out;
    flags_out[cbc_pkg::FL_Z] = (result == 8'h00);
    flags_out[cbc_pkg::FL_N] = result[7];
    flags_out[cbc_pkg::FL_V] = result[7] ^ c_out;
  end

endmodule

//--- design/cbc_rmw.sv
// write-back value for the atomic data ram exchange group
// assumes ram_val is the old ram byte and reg_val the old register byte
`timescale 1ns/100ps
module cbc_rmw (
  input  logic [4:0] op,
  input  logic [7:0] reg_val,
  input  logic [7:0] ram_val,
  output logic [7:0] wdata
);

  // ----------------------------------------------------------------
  // merge of register and ram byte
  // ----------------------------------------------------------------
  always_comb begin
    unique case (op)
      cbc_pkg::OP_LDSET: wdata = reg_val | ram_val;
      cbc_pkg::OP_LDCLR: wdata = (cbc_pkg::ONES - reg_val) & ram_val;
      cbc_pkg::OP_LDTGL: wdata = reg_val ^ ram_val;
      default:         wdata = reg_val;
    endcase
  end

endmodule

//--- design/cbc_core.sv
// execution unit for transfer, bit and control instructions
// assumes io_rdata follows io_addr in the same cycle and dm_rdata
// arrives one cycle after an unstalled read; wishbone master is classic
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/100ps

// What this block does
// - program store writes r1:r0 to program memory at extension:pointer then adds 2 to the pointer, no flags.
// - io input copies the io location into a register and io output copies a register out, 1 cycle, no flags.
// - push stores a register at the stack pointer in 1 cycle, no flags.
// - pop loads a register from the stack in 2 cycles, no flags.
// - load-and-set returns the old ram byte and writes back register OR ram; exchange swaps; 2 cycles.
// - load-and-clear returns the old ram byte and writes back ram AND (FFh minus register), 2 cycles.
// - load-and-toggle returns the old ram byte and writes back register XOR ram, 2 cycles.
// - left rotate and left shift move bits up with carry from bit 7 and update Z C N V H in 1 cycle.
// - right rotate and right shifts move bits down with carry from bit 0 and update Z C N V in 1 cycle.
// - io bit set forces one io bit to one in 1 cycle, other bits and flags kept.
// - io bit clear forces one io bit to zero in 1 cycle, other bits and flags kept.
// - bit store copies a register bit into the transfer flag only, in 1 cycle.
// - bit load copies the transfer flag into a register bit in 1 cycle, flags kept.
// - flag set and clear change exactly one status flag in 1 cycle.
// - break, no-operation, sleep and watchdog restart take 1 cycle and keep the flags.
// - data memory cycle counts hold for internal memory; a stall from the memory lengthens them.
// - a load from internal ram spends one extra cycle on top of its base count.
module cbc_core #(
  parameter int DM_AW = 16
) (
  input  logic             clk,
  input  logic             reset_n,
  input  logic             wb_cyc_i,
  input  logic             wb_stb_i,
  input  logic             wb_we_i,
  input  logic [7:0]       wb_adr_i,
  input  logic [3:0]       wb_sel_i,
  input  logic [31:0]      wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             dm_re,
  output logic             dm_we,
  output logic [DM_AW-1:0] dm_addr,
  output logic [7:0]       dm_wdata,
  input  logic [7:0]       dm_rdata,
  input  logic             dm_stall,
  output logic             io_re,
  output logic             io_we,
  output logic [5:0]       io_addr,
  output logic [7:0]       io_wdata,
  input  logic [7:0]       io_rdata,
  output logic             pm_we,
  output logic [23:0]      pm_addr,
  output logic [15:0]      pm_wdata,
  input  logic             pm_stall,
  output logic             break_pulse,
  output logic             sleep_pulse,
  output logic             wdog_pulse,
  output logic             busy
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (DM_AW < 8 || DM_AW > 16) begin : g_bad_aw
    $error("DM_AW must lie between 8 and 16");
  end

  localparam logic [DM_AW-1:0] SP_ONE = DM_AW'(1);

  cbc_pkg::cbc_state_t state;
  cbc_pkg::cbc_state_t next_state;
  logic [7:0]          gpr [32];
  logic [7:0]          next_gpr [32];
  logic [7:0]          flags;
  logic [7:0]          next_flags;
  logic [7:0]          ext;
  logic [7:0]          next_ext;
  logic [DM_AW-1:0]    sp;
  logic [DM_AW-1:0]    next_sp;
  logic [31:0]         instr;
  logic [31:0]         next_instr;
  logic [31:0]         cycles;
  logic [31:0]         next_cycles;
  logic [31:0]         next_dat;
  logic [4:0]          gsel;
  logic [4:0]          next_gsel;
  logic                next_ack;
  logic                take;
  logic                wr;
  logic [4:0]          op;
  logic [4:0]          rsel;
  logic [2:0]          bsel;
  logic [7:0]          rval;
  logic [15:0]         zp;
  logic [7:0]          sh_res;
  logic [7:0]          sh_flags;
  logic [7:0]          rmw_data;
  logic [31:0]         sp_m;

  // byte lane mask from the wishbone select lines
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // merge written lanes into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    merge = (old & ~lane_mask(sel)) | (nw & lane_mask(sel));
  endfunction

  // one-hot mask of a bit within a byte
  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction

  // byte-wide registers sit in lane 0 only
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    merge8 = sel[0] ? nw[7:0] : old;
  endfunction

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  assign take = wb_cyc_i & wb_stb_i & wb_ack_o;
  assign wr   = take & wb_we_i;
  assign op   = instr[cbc_pkg::F_OP_LSB +: cbc_pkg::OP_W];
  assign rsel = instr[cbc_pkg::F_REG_LSB +: cbc_pkg::REG_W];
  assign bsel = instr[cbc_pkg::F_BIT_LSB +: cbc_pkg::BIT_W];
  assign rval = gpr[rsel];
  assign zp   = {gpr[cbc_pkg::R_ZHI], gpr[cbc_pkg::R_ZLO]};
  assign busy = (state != cbc_pkg::S_IDLE);
  assign sp_m = merge(32'(sp), wb_dat_i, wb_sel_i);

  cbc_shift u_shift (
    .op       (op),
    .value    (rval),
    .flags_in  (flags),
    .result    (sh_res),
    .flags_out (sh_flags)
  );

  cbc_rmw u_rmw (
    .op      (op),
    .reg_val (rval),
    .ram_val (dm_rdata),
    .wdata   (rmw_data)
  );

  // ----------------------------------------------------------------
  // wishbone slave: ack one cycle after the request, reads registered
  // ----------------------------------------------------------------
  always_comb begin
    next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_dat = wb_dat_o;
    // latched as the request is seen, so the data stands in the ack cycle
    if (next_ack && !wb_we_i) begin
      unique case (wb_adr_i)
        cbc_pkg::OFS_INSTR:    next_dat = instr;
        cbc_pkg::OFS_STATUS:   next_dat = {23'h0, busy, flags};
        cbc_pkg::OFS_GPR_SEL:  next_dat = {27'h0, gsel};
        cbc_pkg::OFS_GPR_DATA: next_dat = {24'h000000, gpr[gsel]};
        cbc_pkg::OFS_PTR_EXT:  next_dat = {24'h000000, ext};
        cbc_pkg::OFS_STACK:    next_dat = 32'(sp);
        cbc_pkg::OFS_CYCLES:   next_dat = cycles;
        default:               next_dat = 32'h00000000;  // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ----------------------------------------------------------------
  // execution sequencer; software writes to core state, except the register select, only land
  // while idle, so a running instruction never sees them change
  // ----------------------------------------------------------------
  always_comb begin
    next_state  = state;
    next_gpr    = gpr;
    next_flags  = flags;
    next_ext    = ext;
    next_sp     = sp;
    next_instr  = instr;
    next_cycles = cycles;
    next_gsel   = gsel;
    dm_re       = 1'b0;
    dm_we       = 1'b0;
    dm_addr     = zp[DM_AW-1:0];
    dm_wdata    = rval;
    io_re       = 1'b0;
    io_we       = 1'b0;
    io_addr     = instr[cbc_pkg::F_IOA_LSB +: cbc_pkg::IOA_W];
    io_wdata    = rval;
    pm_we       = 1'b0;
    pm_addr     = {ext, zp};
    pm_wdata    = {gpr[cbc_pkg::R_HI], gpr[cbc_pkg::R_LO]};
    break_pulse = 1'b0;
    sleep_pulse = 1'b0;
    wdog_pulse  = 1'b0;
    if (wr && wb_adr_i == cbc_pkg::OFS_GPR_SEL) begin
      next_gsel = wb_dat_i[4:0];
    end
    if (busy) begin
      next_cycles = cycles + 32'h00000001;
    end
    unique case (state)
      cbc_pkg::S_IDLE: begin
        if (wr) begin
          unique case (wb_adr_i)
            cbc_pkg::OFS_INSTR: begin
              next_instr = merge(instr, wb_dat_i, wb_sel_i);
              next_state = cbc_pkg::S_EXEC;
            end
            cbc_pkg::OFS_STATUS:   next_flags = merge8(flags, wb_dat_i, wb_sel_i);
            cbc_pkg::OFS_GPR_DATA: next_gpr[gsel] = merge8(gpr[gsel], wb_dat_i, wb_sel_i);
            cbc_pkg::OFS_PTR_EXT:  next_ext = merge8(ext, wb_dat_i, wb_sel_i);
            cbc_pkg::OFS_STACK:    next_sp = sp_m[DM_AW-1:0];
            default:               next_state = state;
          endcase
        end
      end
      cbc_pkg::S_EXEC: begin
        next_state = cbc_pkg::S_IDLE;
        unique case (op)
          cbc_pkg::OP_PSTORE: begin
            // a stall holds the store; the pointer moves only once it is taken
            pm_we = 1'b1;
            if (pm_stall) begin
              next_state = state;
            end else begin
              {next_ext, next_gpr[cbc_pkg::R_ZHI], next_gpr[cbc_pkg::R_ZLO]} =
                {ext, zp} + cbc_pkg::PSTORE_STEP;
            end
          end
          cbc_pkg::OP_IN: begin
            io_re = 1'b1;
            next_gpr[rsel] = io_rdata;
          end
          cbc_pkg::OP_OUT: io_we = 1'b1;
          cbc_pkg::OP_PUSH: begin
            dm_we   = 1'b1;
            dm_addr = sp;
            if (dm_stall) begin
              next_state = state;
            end else begin
              next_sp = sp - SP_ONE;
            end
          end
          cbc_pkg::OP_POP: begin
            // the load spends its extra internal ram cycle waiting for data
            dm_re   = 1'b1;
            dm_addr = sp + SP_ONE;
            if (dm_stall) begin
              next_state = state;
            end else begin
              next_sp    = sp + SP_ONE;
              next_state = cbc_pkg::S_SECOND;
            end
          end
          cbc_pkg::OP_EXCH, cbc_pkg::OP_LDSET, cbc_pkg::OP_LDCLR, cbc_pkg::OP_LDTGL: begin
            dm_re      = 1'b1;
            next_state = dm_stall ? state : cbc_pkg::S_SECOND;
          end
          cbc_pkg::OP_SHL, cbc_pkg::OP_RCL, cbc_pkg::OP_SHR, cbc_pkg::OP_RCR, cbc_pkg::OP_SAR: begin
            next_gpr[rsel] = sh_res;
            next_flags     = sh_flags;
          end
          cbc_pkg::OP_IOSET: begin
            io_re    = 1'b1;
            io_we    = 1'b1;
            io_wdata = io_rdata | bit_mask(bsel);
          end
          cbc_pkg::OP_IOCLR: begin
            io_re    = 1'b1;
            io_we    = 1'b1;
            io_wdata = io_rdata & ~bit_mask(bsel);
          end
          cbc_pkg::OP_TSTORE: next_flags[cbc_pkg::FL_T] = rval[bsel];
          cbc_pkg::OP_TLOAD:  next_gpr[rsel][bsel] = flags[cbc_pkg::FL_T];
          cbc_pkg::OP_FSET:   next_flags[bsel] = 1'b1;
          cbc_pkg::OP_FCLR:   next_flags[bsel] = 1'b0;
          cbc_pkg::OP_BRK:    break_pulse = 1'b1;
          cbc_pkg::OP_SLP:    sleep_pulse = 1'b1;
          cbc_pkg::OP_WATCH:  wdog_pulse = 1'b1;
          default:          next_state = cbc_pkg::S_IDLE;  // no-operation and unused codes
        endcase
      end
      cbc_pkg::S_SECOND: begin
        // read data is only trusted once the memory stops stalling
        if (dm_stall) begin
          next_state = state;
        end else begin
          next_state     = cbc_pkg::S_IDLE;
          next_gpr[rsel] = dm_rdata;
          if (op != cbc_pkg::OP_POP) begin
            dm_we    = 1'b1;
            dm_wdata = rmw_data;
          end
        end
      end
      default: next_state = cbc_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state  <= cbc_pkg::S_IDLE;
      gpr    <= '{default: 8'h00};
      flags  <= cbc_pkg::FLAGS_RESET;
      ext    <= cbc_pkg::EXT_RESET;
      sp     <= cbc_pkg::SP_RESET[DM_AW-1:0];
      instr  <= 32'h00000000;
      cycles <= 32'h00000000;
      gsel   <= 5'h00;
    end else begin
      state  <= next_state;
      gpr    <= next_gpr;
      flags  <= next_flags;
      ext    <= next_ext;
      sp     <= next_sp;
      instr  <= next_instr;
      cycles <= next_cycles;
      gsel   <= next_gsel;
    end
  end

  // ----------------------------------------------------------------
  // assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic ex;
  logic sec;
  assign ex  = (state == cbc_pkg::S_EXEC);
  assign sec = (state == cbc_pkg::S_SECOND) && !dm_stall;

  AST_PSTORE_STEP: assert property (ex && op == cbc_pkg::OP_PSTORE && !pm_stall |=>
    {ext, zp} == $past({ext, zp}) + cbc_pkg::PSTORE_STEP && $stable(flags))
    else $error("program store pointer or flags wrong");
  AST_IN_ONE: assert property (ex && op == cbc_pkg::OP_IN |=>
    state == cbc_pkg::S_IDLE && gpr[$past(rsel)] == $past(io_rdata) && $stable(flags))
    else $error("io input not done in one cycle");
  AST_PUSH_SP: assert property (ex && op == cbc_pkg::OP_PUSH && !dm_stall |->
    dm_we && dm_wdata == rval ##1 sp == $past(sp) - SP_ONE && !busy)
    else $error("push wrong");
  AST_POP_TWO: assert property (ex && op == cbc_pkg::OP_POP && !dm_stall ##1 !dm_stall |->
    ##1 !busy && $stable(flags))
    else $error("pop not done in two cycles");
  AST_LDSET_WB: assert property (sec && op == cbc_pkg::OP_LDSET |->
    dm_we && dm_wdata == (rval | dm_rdata) ##1 gpr[$past(rsel)] == $past(dm_rdata))
    else $error("load and set wrong");
  AST_LDCLR_WB: assert property (sec && op == cbc_pkg::OP_LDCLR |->
    dm_wdata == (dm_rdata & ~rval))
    else $error("load and clear wrong");
  AST_LDTGL_WB: assert property (sec && op == cbc_pkg::OP_LDTGL |->
    dm_wdata == (dm_rdata ^ rval))
    else $error("load and toggle wrong");
  AST_RCL_C: assert property (ex && op == cbc_pkg::OP_RCL |=>
    flags[cbc_pkg::FL_C] == $past(rval[7]) && gpr[$past(rsel)][0] == $past(flags[cbc_pkg::FL_C]))
    else $error("rotate left carry wrong");
  AST_SAR_MSB: assert property (ex && op == cbc_pkg::OP_SAR |=>
    gpr[$past(rsel)][7] == $past(rval[7]) && flags[cbc_pkg::FL_C] == $past(rval[0]))
    else $error("arithmetic shift wrong");
  AST_IOSET_BIT: assert property (ex && op == cbc_pkg::OP_IOSET |->
    io_we && io_wdata[bsel] && (io_wdata | bit_mask(bsel)) == (io_rdata | bit_mask(bsel)))
    else $error("io bit set wrong");
  AST_TSTORE_T: assert property (ex && op == cbc_pkg::OP_TSTORE |=>
    flags[cbc_pkg::FL_T] == $past(rval[bsel]) && flags[5:0] == $past(flags[5:0]))
    else $error("bit store wrong");

  CVR_PSTORE: cover property (ex && op == cbc_pkg::OP_PSTORE && !pm_stall);
  CVR_POP: cover property (sec && op == cbc_pkg::OP_POP);
  CVR_LDCLR: cover property (sec && op == cbc_pkg::OP_LDCLR);

endmodule

//--- dv/cbc_mem_model.sv
// data memory, io space and program memory facing the execution unit
// assumes DM_AW of 8; reads answer the cycle after an unstalled strobe
`timescale 1ns/100ps
module cbc_mem_model (
  input  logic        clk,
  input  logic        slow,
  input  logic        dm_re,
  input  logic        dm_we,
  input  logic [7:0]  dm_addr,
  input  logic [7:0]  dm_wdata,
  output logic [7:0]  dm_rdata,
  output logic        dm_stall,
  input  logic        io_we,
  input  logic [5:0]  io_addr,
  input  logic [7:0]  io_wdata,
  output logic [7:0]  io_rdata,
  input  logic        pm_we,
  input  logic [23:0] pm_addr,
  input  logic [15:0] pm_wdata,
  output logic        pm_stall
);
  logic [7:0]  dm [256];
  logic [7:0]  io [64];
  logic [23:0] pm_a;
  logic [15:0] pm_d;
  logic        stalled = 1'b0;
  // each read is held once when slow, so a stretched access is exercised
  assign dm_stall = slow & dm_re & ~stalled;
  assign io_rdata = io[io_addr];
  assign pm_stall = 1'b0;
  // an idle read bus keeps flipping so stale data is never mistaken for fresh
  always @(posedge clk) begin
    stalled <= dm_stall;
    dm_rdata <= (dm_re & ~dm_stall) ? dm[dm_addr] : ~dm_rdata;
    if (dm_we) dm[dm_addr] <= dm_wdata;
    if (io_we) io[io_addr] <= io_wdata;
    if (pm_we) begin
      pm_a <= pm_addr;
      pm_d <= pm_wdata;
    end
  end
endmodule

//--- dv/tb_top.sv
// self-checking bench: instructions launched over the wishbone port
// assumes the partner model above and a narrowed data address of 8 bits
`timescale 1ns/100ps
module tb_top;
  logic        clk, reset_n, cyc, stb, we, slow, ack, dm_re, dm_we, dm_stall, io_we, pm_we, pm_stall;
  logic [7:0]  adr, dm_addr, dm_wdata, dm_rdata, io_wdata, io_rdata, st;
  logic [5:0]  io_addr;
  logic [23:0] pm_addr;
  logic [15:0] pm_wdata;
  logic [31:0] dat, rdat, q;
  int          errors = 0, n_tests = 0, cyc_n = 0;
  logic [7:0]  exp_rmw [4] = '{8'h3C, 8'hFD, 8'hC1, 8'hF9};
  logic [7:0]  exp_sh [5] = '{8'h02, 8'h40, 8'h03, 8'hC0, 8'hC0};
  cbc_core #(.DM_AW(8)) uut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .dm_re(dm_re),
    .dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .dm_stall(dm_stall),
    .io_re(), .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .pm_we(pm_we),
    .pm_addr(pm_addr), .pm_wdata(pm_wdata), .pm_stall(pm_stall), .break_pulse(), .sleep_pulse(),
    .wdog_pulse(), .busy());
  cbc_mem_model mdl (.clk(clk), .slow(slow), .dm_re(dm_re), .dm_we(dm_we), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .dm_stall(dm_stall), .io_we(io_we), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .pm_we(pm_we), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
    .pm_stall(pm_stall));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // a hang ends in the same report as a normal run
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic cycle: ack and data taken at the rising edge that samples ack high, released there
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  function automatic logic [31:0] ins(input logic [4:0] op, rg, input logic [2:0] b, input logic [5:0] a);
    return {13'h0000, a, b, rg, op};
  endfunction
  task automatic setr(input logic [4:0] r, input logic [7:0] v);
    wb(1'b1, cbc_pkg::OFS_GPR_SEL, {27'h0, r});
    wb(1'b1, cbc_pkg::OFS_GPR_DATA, {24'h0, v});
  endtask
  task automatic getr(input logic [4:0] r);
    wb(1'b1, cbc_pkg::OFS_GPR_SEL, {27'h0, r});
    wb(1'b0, cbc_pkg::OFS_GPR_DATA, 32'h0);
  endtask
  // launch, wait for idle, then check masked flags and busy cycles spent
  task automatic run(input logic [31:0] i, input int c, input logic [7:0] m);
    logic [31:0] c0;
    wb(1'b0, cbc_pkg::OFS_CYCLES, 32'h0);
    c0 = q;
    wb(1'b1, cbc_pkg::OFS_INSTR, i);
    do wb(1'b0, cbc_pkg::OFS_STATUS, 32'h0); while (q[cbc_pkg::ST_BUSY] !== 1'b0);
    chk(q & {24'h0, m}, {24'h0, st & m});
    wb(1'b0, cbc_pkg::OFS_CYCLES, 32'h0);
    chk(q - c0, 32'(c));
  endtask
  initial begin
    reset_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0; slow = 1'b0; st = 8'h00;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, cbc_pkg::OFS_STATUS, 32'h0); chk(q, 32'h0);
    wb(1'b0, cbc_pkg::OFS_STACK, 32'h0); chk(q, 32'hFF);
    mdl.io[5] = 8'hA7;
    run(ins(5'h05, 5'h02, 3'h0, 6'h05), 1, 8'hFF); getr(5'h02); chk(q, 32'hA7);
    setr(5'h03, 8'h5C); run(ins(5'h06, 5'h03, 3'h0, 6'h07), 1, 8'hFF); chk(mdl.io[7], 32'h5C);
    run(ins(5'h07, 5'h03, 3'h0, 6'h00), 1, 8'hFF); chk(mdl.dm[255], 32'h5C);
    run(ins(5'h08, 5'h04, 3'h0, 6'h00), 2, 8'hFF); getr(5'h04); chk(q, 32'h5C);
    setr(5'h1E, 8'h20); setr(5'h1F, 8'h00);
    // odd passes stall the read once, adding one cycle
    for (int k = 0; k < 4; k++) begin
      mdl.dm[32] = 8'hC5; setr(5'h05, 8'h3C); slow <= k[0];
      run(ins(5'h09 + 5'(k), 5'h05, 3'h0, 6'h00), 2 + k % 2, 8'hFF);
      getr(5'h05); chk(q, 32'hC5); chk(mdl.dm[32], exp_rmw[k]);
    end
    slow <= 1'b0; st = 8'h01;
    for (int k = 0; k < 5; k++) begin
      setr(5'h08, 8'h81); run(ins(5'h16, 5'h00, 3'h0, 6'h00), 1, 8'h01);
      run(ins(5'h0D + 5'(k), 5'h08, 3'h0, 6'h00), 1, 8'h01); getr(5'h08); chk(q, exp_sh[k]);
    end
    st = 8'h00;
    for (int b = 0; b < 8; b++) run(ins(5'h17, 5'h00, 3'(b), 6'h00), 1, 8'h00);
    for (int b = 0; b < 8; b++) begin
      st = 8'h01 << b; run(ins(5'h16, 5'h00, 3'(b), 6'h00), 1, 8'hFF);
      st = 8'h00; run(ins(5'h17, 5'h00, 3'(b), 6'h00), 1, 8'hFF);
    end
    mdl.io[9] = 8'h00; run(ins(5'h12, 5'h00, 3'h3, 6'h09), 1, 8'hFF); chk(mdl.io[9], 32'h08);
    mdl.io[9] = 8'hFF; run(ins(5'h13, 5'h00, 3'h3, 6'h09), 1, 8'hFF); chk(mdl.io[9], 32'hF7);
    setr(5'h06, 8'h10); st = 8'h40; run(ins(5'h14, 5'h06, 3'h4, 6'h00), 1, 8'hFF);
    setr(5'h07, 8'h00); run(ins(5'h15, 5'h07, 3'h2, 6'h00), 1, 8'hFF); getr(5'h07); chk(q, 32'h04);
    for (int k = 0; k < 4; k++) run(ins(5'(k), 5'h00, 3'h0, 6'h00), 1, 8'hFF);
    setr(5'h00, 8'h34); setr(5'h01, 8'h12); setr(5'h1E, 8'hFE); setr(5'h1F, 8'hFF);
    wb(1'b1, cbc_pkg::OFS_PTR_EXT, 32'h01);
    run(ins(5'h04, 5'h00, 3'h0, 6'h00), 1, 8'hFF); chk(mdl.pm_a, 32'h01FFFE); chk(mdl.pm_d, 32'h1234);
    getr(5'h1E); chk(q, 32'h0); getr(5'h1F); chk(q, 32'h0);
    wb(1'b0, cbc_pkg::OFS_PTR_EXT, 32'h0); chk(q, 32'h02);
    wb(1'b0, 8'h1C, 32'h0); chk(q, 32'h0);
    stop_test();
  end
endmodule
